// ===== hdl/stc_pkg.sv
// Constants, register map and record layouts for the star transit capture block
package stc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADVANCE_NS    = 400;
    localparam int ADVANCE_CYC   = (ADVANCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ADVANCE_CNT = 4'(ADVANCE_CYC);

    // ****************************************************************
    // Field widths and positions
    // ****************************************************************
    localparam int INTERP_W  = 6;
    localparam int BAR_W     = 8;
    localparam int WIDTH_W   = 3;
    localparam int POS_W     = 19;
    localparam int FLAGS_W   = 5;
    localparam int REC_W     = 25;
    localparam int DELTA_W   = WIDTH_W + INTERP_W;
    localparam int TYPE_BIT  = 24;
    localparam int MARK_LO   = 19;
    localparam int MARK_HI   = 23;
    localparam logic [FLAGS_W-1:0] X_MARK = 5'h1f;

    // ****************************************************************
    // Register map and reset values
    // ****************************************************************
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [5:0] CTRL_RST   = 6'h00;
    localparam int CTRL_FAST_BIT = 0;
    localparam int CTRL_FLAG_LO  = 1;

    // Star transit record as held in the assembly register
    typedef struct packed {
        logic                rtype;
        logic                rsv;
        logic [WIDTH_W-1:0]  width;
        logic [INTERP_W-1:0] eg_interp;
        logic [BAR_W-1:0]    bar;
        logic [INTERP_W-1:0] in_interp;
    } transit_rec_t;

    // Source feeding the head of the buffer chain
    typedef enum logic [1:0] {
        SRC_NONE    = 2'b00,
        SRC_Y       = 2'b01,
        SRC_X       = 2'b10,
        SRC_TRANSIT = 2'b11
    } src_t;

endpackage : stc_pkg

// ===== hdl/chain_stage.sv
// One flagged register of the buffer chain toward memory
`timescale 1ns/1ns
module chain_stage #(
    parameter int W = 25
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         up_flag,
    input  wire logic [W-1:0] up_data,
    input  wire logic         dn_take,
    output logic              up_take,
    output logic              flag,
    output logic [W-1:0]      data
);

    logic         flag_ff;
    logic         nxt_flag;
    logic [W-1:0] data_ff;
    logic [W-1:0] nxt_data;

    // Take from upstream only while empty
    always_comb begin
        up_take  = up_flag && !flag_ff;
        nxt_flag = up_take | (flag_ff & ~dn_take);
        nxt_data = up_take ? up_data : data_ff;
    end

    // Stage registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_ff <= 1'b0;
            data_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
            data_ff <= nxt_data;
        end
    end

    assign flag = flag_ff;
    assign data = data_ff;

    // Full stage keeps its word until taken
    full_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        flag_ff && !dn_take |=> flag_ff && $stable(data_ff))
        else $error("full stage lost its word");

    // Taken stage goes empty
    take_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        flag_ff && dn_take |=> !flag_ff)
        else $error("stage flag not cleared after transfer");

endmodule : chain_stage

// ===== hdl/star_transit_capture.sv
// Star transit capture: counters, holding registers, assembly and buffer chain to memory
// Functional notes
// - Stripe Y sampled once, recorded first
// - Y record: 19 bits plus five flag bits
// - X sampled each scan, interleaved with transits
// - X record bits 19..23 forced one
// - Bit 24: one for X, zero transit
// - Only transit records pass the width adder
// - Interpolation tick direct or divided, by speed
// - Interpolation zeroed on first tick after bar
// - Same pulse advances bar counter, 14-bit position
// - Bar counter cleared at scan start, checked
// - Enabled width counter advances with bar advance
// - Width enable waits for advance to finish
// - Width enable set when interpolation MSB high
// - Holding registers track counters until frozen
// - Ingress freezes bar, interp hold; flags ready
// - Ingress enters assembly when assembly is free
// - Ingress holds resume tracking after copy
// - Egress freezes width, interp hold; same transfer
// - Complete assembly sets flag, moves to buffer
// - Every chain register carries a data flag
// - Records advance to final stage, then memory
// - Transfer clears source flag, sets destination
// - Final stage requests memory, waits acknowledge
`timescale 1ns/1ns
module star_transit_capture #(
    parameter int BUF_STAGES  = 3,
    parameter int INTERP_DIV  = 2,
    parameter int EXPECT_BARS = 250
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [7:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic [31:0]                     rdata,
    input  wire logic                       reticle_bar,
    input  wire logic                       stripe_start,
    input  wire logic                       scan_start,
    input  wire logic                       scan_end,
    input  wire logic                       star_ingress,
    input  wire logic                       star_egress,
    input  wire logic [stc_pkg::POS_W-1:0]  stripe_y_counter,
    input  wire logic [stc_pkg::POS_W-1:0]  x_position_counter,
    input  wire logic                       mem_ack,
    output logic                            mem_req,
    output logic [stc_pkg::REC_W-1:0]       mem_data,
    output logic                            parity_error
);

    localparam int RW = stc_pkg::REC_W;
    localparam int IW = stc_pkg::INTERP_W;
    localparam int BW = stc_pkg::BAR_W;
    localparam int WW = stc_pkg::WIDTH_W;
    localparam logic [3:0]    DIV_LAST = 4'(INTERP_DIV - 1);
    localparam logic [BW-1:0] BAR_END  = BW'(EXPECT_BARS);

    // ****************************************************************
    // Register port
    // ****************************************************************
    logic [5:0]  ctrl_ff;
    logic [5:0]  nxt_ctrl;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] status_word;

    // Decode writes and reads; read data lasts one cycle
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_rdata = 32'h0000_0000;
        if (wr && addr == stc_pkg::CTRL_OFF) begin
            nxt_ctrl = wdata[5:0];
        end
        if (rd) begin
            if (addr == stc_pkg::CTRL_OFF) begin
                nxt_rdata = {26'h000_0000, ctrl_ff};
            end else if (addr == stc_pkg::STATUS_OFF) begin
                nxt_rdata = status_word;
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    // Bus registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff  <= stc_pkg::CTRL_RST;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************************************
    // Interpolation, bar and width counters
    // ****************************************************************
    logic [3:0]    div_ff, nxt_div;
    logic          ret_prev_ff, nxt_ret_prev;
    logic          zero_pend_ff, nxt_zero_pend;
    logic [IW-1:0] interp_ff, nxt_interp;
    logic [BW-1:0] bar_ff, nxt_bar;
    logic [WW-1:0] width_ff, nxt_width;
    logic [3:0]    busy_ff, nxt_busy;
    logic          arm_ff, nxt_arm;
    logic          wen_ff, nxt_wen;
    logic          perr_ff, nxt_perr;
    logic          tick;
    logic          advance;

    // Counting, zeroing and width enable
    always_comb begin
        tick          = ctrl_ff[stc_pkg::CTRL_FAST_BIT] || (div_ff == DIV_LAST);
        advance       = tick && zero_pend_ff;
        nxt_div       = (tick || ctrl_ff[stc_pkg::CTRL_FAST_BIT]) ? 4'h0 : div_ff + 4'h1;
        nxt_ret_prev  = reticle_bar;
        nxt_zero_pend = (reticle_bar && !ret_prev_ff) || (zero_pend_ff && !tick);
        nxt_interp    = interp_ff;
        nxt_bar       = bar_ff;
        nxt_width     = width_ff;
        nxt_busy      = (busy_ff != 4'h0) ? busy_ff - 4'h1 : 4'h0;
        nxt_arm       = arm_ff;
        nxt_wen       = wen_ff;
        nxt_perr      = perr_ff;
        if (advance) begin
            nxt_interp = '0;
            nxt_bar    = bar_ff + BW'(1);
            nxt_busy   = stc_pkg::ADVANCE_CNT;
            if (wen_ff) begin
                nxt_width = width_ff + WW'(1);
            end
        end else if (tick) begin
            nxt_interp = interp_ff + IW'(1);
        end
        if (scan_start) begin
            nxt_bar = '0;
        end
        if (scan_end) begin
            nxt_perr = (bar_ff != BAR_END);
        end
        if (arm_ff && interp_ff[IW-1] && busy_ff == 4'h0) begin
            nxt_wen = 1'b1;
            nxt_arm = 1'b0;
        end
        if (star_ingress) begin
            nxt_width = '0;
            nxt_arm   = 1'b1;
            nxt_wen   = 1'b0;
        end
        if (star_egress) begin
            nxt_arm = 1'b0;
            nxt_wen = 1'b0;
        end
    end

    // Counter registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_ff       <= 4'h0;
            ret_prev_ff  <= 1'b0;
            zero_pend_ff <= 1'b0;
            interp_ff    <= '0;
            bar_ff       <= '0;
            width_ff     <= '0;
            busy_ff      <= 4'h0;
            arm_ff       <= 1'b0;
            wen_ff       <= 1'b0;
            perr_ff      <= 1'b0;
        end else begin
            div_ff       <= nxt_div;
            ret_prev_ff  <= nxt_ret_prev;
            zero_pend_ff <= nxt_zero_pend;
            interp_ff    <= nxt_interp;
            bar_ff       <= nxt_bar;
            width_ff     <= nxt_width;
            busy_ff      <= nxt_busy;
            arm_ff       <= nxt_arm;
            wen_ff       <= nxt_wen;
            perr_ff      <= nxt_perr;
        end
    end

    // ****************************************************************
    // Holding registers and assembly register
    // ****************************************************************
    logic [BW-1:0] bar_h_ff, nxt_bar_h;
    logic [IW-1:0] in_i_h_ff, nxt_in_i_h;
    logic [WW-1:0] width_h_ff, nxt_width_h;
    logic [IW-1:0] eg_i_h_ff, nxt_eg_i_h;
    logic          in_rdy_ff, nxt_in_rdy;
    logic          eg_rdy_ff, nxt_eg_rdy;
    stc_pkg::transit_rec_t a_rec_ff, nxt_a_rec;
    logic          a_in_ff, nxt_a_in;
    logic          a_eg_ff, nxt_a_eg;
    logic          a_flag_ff, nxt_a_flag;
    logic          move_in;
    logic          move_eg;
    logic          a_taken;

    // Track, freeze and merge into assembly
    always_comb begin
        move_in     = in_rdy_ff && !a_in_ff && !a_flag_ff;
        move_eg     = eg_rdy_ff && !a_eg_ff && !a_flag_ff;
        nxt_in_rdy  = in_rdy_ff && !move_in;
        nxt_eg_rdy  = eg_rdy_ff && !move_eg;
        nxt_bar_h   = in_rdy_ff ? bar_h_ff : bar_ff;
        nxt_in_i_h  = in_rdy_ff ? in_i_h_ff : interp_ff;
        nxt_width_h = eg_rdy_ff ? width_h_ff : width_ff;
        nxt_eg_i_h  = eg_rdy_ff ? eg_i_h_ff : interp_ff;
        if (star_ingress && (!in_rdy_ff || move_in)) begin
            nxt_bar_h  = bar_ff;
            nxt_in_i_h = interp_ff;
            nxt_in_rdy = 1'b1;
        end
        if (star_egress && (!eg_rdy_ff || move_eg)) begin
            nxt_width_h = width_ff;
            nxt_eg_i_h  = interp_ff;
            nxt_eg_rdy  = 1'b1;
        end
        nxt_a_rec  = a_rec_ff;
        nxt_a_in   = a_in_ff || move_in;
        nxt_a_eg   = a_eg_ff || move_eg;
        nxt_a_flag = a_flag_ff && !a_taken;
        nxt_a_rec.rtype = 1'b0;
        nxt_a_rec.rsv   = 1'b0;
        if (move_in) begin
            nxt_a_rec.bar       = bar_h_ff;
            nxt_a_rec.in_interp = in_i_h_ff;
        end
        if (move_eg) begin
            nxt_a_rec.width     = width_h_ff;
            nxt_a_rec.eg_interp = eg_i_h_ff;
        end
        if (nxt_a_in && nxt_a_eg) begin
            nxt_a_flag = 1'b1;
            nxt_a_in   = 1'b0;
            nxt_a_eg   = 1'b0;
        end
    end

    // Holding and assembly registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bar_h_ff   <= '0;
            in_i_h_ff  <= '0;
            width_h_ff <= '0;
            eg_i_h_ff  <= '0;
            in_rdy_ff  <= 1'b0;
            eg_rdy_ff  <= 1'b0;
            a_rec_ff   <= '0;
            a_in_ff    <= 1'b0;
            a_eg_ff    <= 1'b0;
            a_flag_ff  <= 1'b0;
        end else begin
            bar_h_ff   <= nxt_bar_h;
            in_i_h_ff  <= nxt_in_i_h;
            width_h_ff <= nxt_width_h;
            eg_i_h_ff  <= nxt_eg_i_h;
            in_rdy_ff  <= nxt_in_rdy;
            eg_rdy_ff  <= nxt_eg_rdy;
            a_rec_ff   <= nxt_a_rec;
            a_in_ff    <= nxt_a_in;
            a_eg_ff    <= nxt_a_eg;
            a_flag_ff  <= nxt_a_flag;
        end
    end

    // ****************************************************************
    // Position records and chain head
    // ****************************************************************
    logic          y_pend_ff, nxt_y_pend;
    logic [RW-1:0] y_rec_ff, nxt_y_rec;
    logic          x_pend_ff, nxt_x_pend;
    logic [RW-1:0] x_rec_ff, nxt_x_rec;
    stc_pkg::src_t             head_src;
    logic                      head_flag;
    logic [RW-1:0]             head_data;
    wire  logic [BUF_STAGES:0] stg_flag;
    wire  logic [BUF_STAGES:0] stg_take;
    wire  logic [RW-1:0]       stg_data [BUF_STAGES:0];

    // Pick the head source: Y first, then X, then transit
    always_comb begin
        if (y_pend_ff) begin
            head_src = stc_pkg::SRC_Y;
        end else if (x_pend_ff) begin
            head_src = stc_pkg::SRC_X;
        end else if (a_flag_ff) begin
            head_src = stc_pkg::SRC_TRANSIT;
        end else begin
            head_src = stc_pkg::SRC_NONE;
        end
        head_flag = 1'b1;
        case (head_src)
            stc_pkg::SRC_Y:       head_data = y_rec_ff;
            stc_pkg::SRC_X:       head_data = x_rec_ff;
            stc_pkg::SRC_TRANSIT: head_data = a_rec_ff;
            default: begin
                head_data = '0;
                head_flag = 1'b0;
            end
        endcase
        a_taken    = stg_take[0] && head_src == stc_pkg::SRC_TRANSIT;
        nxt_y_pend = y_pend_ff && !(stg_take[0] && head_src == stc_pkg::SRC_Y);
        nxt_x_pend = x_pend_ff && !(stg_take[0] && head_src == stc_pkg::SRC_X);
        nxt_y_rec  = y_rec_ff;
        nxt_x_rec  = x_rec_ff;
        if (stripe_start) begin
            nxt_y_pend = 1'b1;
            nxt_y_rec  = {1'b1, ctrl_ff[stc_pkg::CTRL_FLAG_LO +: stc_pkg::FLAGS_W], stripe_y_counter};
        end
        if (scan_start) begin
            nxt_x_pend = 1'b1;
            nxt_x_rec  = {1'b1, stc_pkg::X_MARK, x_position_counter};
        end
    end

    // Chain head feeds the first buffer stage
    assign stg_flag[0] = head_flag;
    assign stg_data[0] = head_data;

    // Position record registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            y_pend_ff <= 1'b0;
            y_rec_ff  <= '0;
            x_pend_ff <= 1'b0;
            x_rec_ff  <= '0;
        end else begin
            y_pend_ff <= nxt_y_pend;
            y_rec_ff  <= nxt_y_rec;
            x_pend_ff <= nxt_x_pend;
            x_rec_ff  <= nxt_x_rec;
        end
    end

    // ****************************************************************
    // Buffer chain and memory feed stage
    // ****************************************************************
    logic          feed_flag_ff, nxt_feed_flag;
    logic [RW-1:0] feed_data_ff, nxt_feed_data;
    logic [stc_pkg::DELTA_W-1:0] delta;
    logic          feed_take;

    // Feed stage takes from the last buffer stage
    assign stg_take[BUF_STAGES] = feed_take;

    // Flagged buffer registers
    generate
        for (genvar i = 0; i < BUF_STAGES; i++) begin : g_buf
            chain_stage #(.W(RW)) u_stage (
                .clk     (clk),
                .resetn  (resetn),
                .up_flag (stg_flag[i]),
                .up_data (stg_data[i]),
                .dn_take (stg_take[i+1]),
                .up_take (stg_take[i]),
                .flag    (stg_flag[i+1]),
                .data    (stg_data[i+1])
            );
        end
    endgenerate

    // Final stage: width adder on transits, memory handshake
    always_comb begin
        feed_take     = stg_flag[BUF_STAGES] && !feed_flag_ff;
        delta         = stg_data[BUF_STAGES][22:14] - {3'h0, stg_data[BUF_STAGES][5:0]};
        nxt_feed_flag = feed_take || (feed_flag_ff && !mem_ack);
        nxt_feed_data = feed_data_ff;
        if (feed_take) begin
            if (stg_data[BUF_STAGES][stc_pkg::TYPE_BIT]) begin
                nxt_feed_data = stg_data[BUF_STAGES];
            end else begin
                nxt_feed_data = {2'b00, delta, stg_data[BUF_STAGES][13:0]};
            end
        end
    end

    // Feed stage registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feed_flag_ff <= 1'b0;
            feed_data_ff <= '0;
        end else begin
            feed_flag_ff <= nxt_feed_flag;
            feed_data_ff <= nxt_feed_data;
        end
    end

    assign status_word  = {25'h000_0000, perr_ff, feed_flag_ff, a_flag_ff, eg_rdy_ff, in_rdy_ff, arm_ff, wen_ff};
    assign rdata        = rdata_ff;
    assign mem_req      = feed_flag_ff;
    assign mem_data     = feed_data_ff;
    assign parity_error = perr_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    interp_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        advance |=> interp_ff == '0)
        else $error("interpolation not zeroed on advance");

    bar_step_a: assert property (@(posedge clk) disable iff (!resetn)
        advance && !scan_start |=> bar_ff == $past(bar_ff) + BW'(1))
        else $error("bar counter did not advance with zeroing");

    bar_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        scan_start |=> bar_ff == '0)
        else $error("bar counter not cleared at scan start");

    width_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(wen_ff) |-> $past(interp_ff[IW-1]) && $past(busy_ff) == 4'h0)
        else $error("width enabled outside safe zone");

    x_mark_a: assert property (@(posedge clk) disable iff (!resetn)
        x_pend_ff |-> x_rec_ff[stc_pkg::MARK_HI:stc_pkg::MARK_LO] == stc_pkg::X_MARK && x_rec_ff[stc_pkg::TYPE_BIT])
        else $error("position record marker wrong");

    ingress_freeze_a: assert property (@(posedge clk) disable iff (!resetn)
        star_ingress && !in_rdy_ff |=> in_rdy_ff && bar_h_ff == $past(bar_ff))
        else $error("ingress did not freeze holds");

    x_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        stg_take[BUF_STAGES] && stg_data[BUF_STAGES][stc_pkg::TYPE_BIT] |=> mem_data == $past(stg_data[BUF_STAGES]))
        else $error("position record altered by adder");

    req_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        mem_req && !mem_ack |=> mem_req && $stable(mem_data))
        else $error("memory request dropped before acknowledge");

    ack_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        mem_req && mem_ack |=> !mem_req)
        else $error("feed flag not cleared after acknowledge");

endmodule : star_transit_capture

// ===== tb/mem_ctrl_model.sv
// Behavioural memory controller answering capture requests
`timescale 1ns/1ns
module mem_ctrl_model (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic mem_req,
    output logic      mem_ack
);
    logic [2:0] wait_ff;

    // One-cycle acknowledge after a random wait
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            wait_ff <= 3'h0;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack) begin
                if (wait_ff == 3'h0) begin
                    mem_ack <= 1'b1;
                    wait_ff <= 3'($urandom);
                end else begin
                    wait_ff <= wait_ff - 3'h1;
                end
            end
        end
    end
endmodule : mem_ctrl_model

// ===== tb/star_transit_capture_bench.sv
// Self-checking bench for the star transit capture block
`timescale 1ns/1ns
module star_transit_capture_bench;
    logic        clk, resetn, wr, rd, bar, mem_ack, mem_req, perr;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [4:0]  ev;
    logic [18:0] y, x;
    logic [5:0]  ctrl;
    logic [24:0] mem_data, w;
    logic [24:0] q[$];
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;

    star_transit_capture #(.EXPECT_BARS(4)) u_star_transit_capture (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .reticle_bar(bar), .stripe_start(ev[0]),
        .scan_start(ev[1]), .scan_end(ev[2]), .star_ingress(ev[3]),
        .star_egress(ev[4]), .stripe_y_counter(y), .x_position_counter(x),
        .mem_ack(mem_ack), .mem_req(mem_req), .mem_data(mem_data),
        .parity_error(perr));
    mem_ctrl_model u_mem_ctrl_model (.clk(clk), .resetn(resetn),
        .mem_req(mem_req), .mem_ack(mem_ack));

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Collect words taken by memory, cut hangs short
    always @(posedge clk) begin
        cyc++;
        if (mem_req === 1'b1 && mem_ack === 1'b1) q.push_back(mem_data);
        if (cyc == 40000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    // One-cycle event pulse on line k
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 5'h01 << k;
        @(posedge clk);
        ev <= 5'h00;
    endtask : pulse

    task automatic bars(input int n);
        repeat (n) begin
            @(posedge clk);
            bar <= 1'b1;
            repeat (64) @(posedge clk);
            bar <= 1'b0;
            repeat (64) @(posedge clk);
        end
    endtask : bars

    task automatic get();
        int i;
        i = 0;
        while (q.size() == 0 && i < 300) begin
            @(posedge clk);
            i++;
        end
        w = (q.size() > 0) ? q.pop_front() : 'x;
    endtask : get

    function automatic logic [24:0] y_word(input logic [5:0] c, input logic [18:0] p);
        return {1'b1, c[5:1], p};
    endfunction : y_word

    function automatic logic [24:0] x_word(input logic [18:0] p);
        return {1'b1, 5'h1f, p};
    endfunction : x_word

    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        bar = 1'b0;
        ev = 5'h00;
        addr = 8'h00;
        wdata = 32'h0;
        y = 19'h0;
        x = 19'h0;
        void'($urandom(32'h0625));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        chk(mem_req, 32'h0);
        rd_reg(8'h00);
        chk(v, 32'h0);
        ctrl = 6'($urandom) | 6'h01;
        wr_reg(8'h00, {26'h0, ctrl});
        rd_reg(8'h00);
        chk(v, {26'h0, ctrl});
        rd_reg(8'h3c);
        chk(v, 32'h0);
        @(posedge clk);
        y <= 19'($urandom);
        x <= 19'($urandom);
        pulse(0);
        pulse(1);
        get();
        chk(w, y_word(ctrl, y));
        get();
        chk(w, x_word(x));
        bars(2);
        pulse(3);
        bars(1);
        pulse(4);
        get();
        chk(w[24:23], 32'h0);
        chk(w[13:6], 32'h2);
        bars(1);
        pulse(3);
        pulse(4);
        get();
        chk(w[13:6], 32'h4);
        pulse(2);
        repeat (3) @(posedge clk);
        chk(perr, 32'h0);
        @(posedge clk);
        x <= 19'($urandom);
        pulse(1);
        get();
        chk(w, x_word(x));
        bars(3);
        pulse(2);
        repeat (3) @(posedge clk);
        chk(perr, 32'h1);
        rd_reg(8'h04);
        chk(v, 32'h40);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk(perr, 32'h0);
        resetn <= 1'b1;
        finish_test();
    end
endmodule : star_transit_capture_bench
